// [uart_async_port.sv]
`timescale 1ns/10ps
// Overview of operation
// - timer 1 baud is 2^double_rate/32 times clk over 4 or 12 times (256-reload).
// - in modes 1 and 3, tx and rx timer-2 select bits pick timer 2 per direction, else timer 1.
// - timer 2 baud is clk/(32*(65536-reload)), reload from high and low bytes.
// - any timer-2 baud select makes timer 2 count at clk/2.
// - timer-2 baud use suppresses overflow flag and external reload trigger.
// - mode 1 sends start, 8 data LSB first, stop after next /16 rollover.
// - mode 1 sets transmit-complete two cycles after the stop bit ends.
// - receive starts on falling edge only with rx enable; /16 counter reset.
// - each bit decided by majority of three mid-bit samples.
// - start bit not confirmed low abandons the frame.
// - mode 1 accepts if flag clear and, with multiprocessor, stop is 1.
// - rejected frame leaves buffer, ninth bit and flag untouched.
// - after mid stop bit the receiver returns to idle always.
// - modes 2 and 3 send 11 bits with ninth bit from control.
// - mode 2 baud is clk/64, or clk/32 with double rate.
// - mode 2 transmit starts at next rollover; flag set as stop is driven.
// - modes 2 and 3 store received ninth bit, data, and raise flag.
// - mode 3 frames as mode 2, clocks as mode 1.
// - multiprocessor in modes 2 and 3 accepts only ninth bit 1.
// - only software clears transmit and receive complete flags.
module uart_async_port
  import uart_async_pkg::*;
(
  // clock, reset, enable
  input  wire logic                                mclk,
  input  wire logic                                rst,
  input  wire logic                                ce,
  // register port
  input  wire logic [uart_async_pkg::ADDR_W-1:0]   addr,
  input  wire logic [uart_async_pkg::DATA_W-1:0]   wdata,
  input  wire logic                                wr,
  input  wire logic                                rd,
  output logic      [uart_async_pkg::DATA_W-1:0]   rdata,
  // pins
  input  wire logic                                rxd,
  input  wire logic                                timer2_external_trigger,
  output logic                                     txd
);
  import uart_async_pkg::*;

  // ==========================================================
  // registers
  ctrl_t       ctrl;
  baud_cfg_t   baud;
  logic [7:0]  timer1_reload_byte;
  logic [7:0]  timer2_reload_high;
  logic [7:0]  timer2_reload_low;
  logic        transmit_complete_flag;
  logic        receive_complete_flag;
  logic        receive_ninth_bit;
  logic [7:0]  serial_buffer;

  wire wr_ctrl   = wr & (addr == OFS_CTRL);
  wire wr_status = wr & (addr == OFS_STATUS);
  wire wr_buffer = wr & (addr == OFS_BUFFER);
  wire wr_baud   = wr & (addr == OFS_BAUD_CTRL);
  wire wr_t1     = wr & (addr == OFS_T1_RELOAD);
  wire wr_t2     = wr & (addr == OFS_T2_RELOAD);
  wire wr_t2st   = wr & (addr == OFS_T2_STATUS);
  wire clr_ti    = wr_status & wdata[ST_TI];
  wire clr_ri    = wr_status & wdata[ST_RI];
  wire nine_mode = ctrl.mode[1];

  // ==========================================================
  // baud sources
  logic t1_ovf;
  logic t2_ovf;
  logic t2_flag;
  logic t1_half;
  logic [1:0] m2_pre;

  baud_timers u_timers (
    .mclk                    (mclk),
    .rst                     (rst),
    .ce                      (ce),
    .cfg                     (baud),
    .timer1_reload_byte      (timer1_reload_byte),
    .t2_reload               ({timer2_reload_high, timer2_reload_low}),
    .timer2_external_trigger (timer2_external_trigger),
    .t2_flag_clear           (wr_t2st & wdata[T2ST_FLAG]),
    .t1_ovf                  (t1_ovf),
    .t2_ovf                  (t2_ovf),
    .timer2_overflow_flag    (t2_flag)
  );

  // timer 1 overflow feeds /32 or /16 of the baud rate, so halve without double rate
  wire t1_tick  = t1_ovf & (baud.double_rate_bit | t1_half);
  wire [1:0] m2_lim = baud.double_rate_bit ? M2_FAST_LAST : M2_SLOW_LAST;
  wire m2_tick  = ce & (m2_pre >= m2_lim);

  function automatic logic pick_tick(input uart_mode_t m, input logic use_t2,
                                     input logic t1t, input logic t2t, input logic m2t);
    if (m == MODE_OFF) begin
      pick_tick = 1'b0;
    end else if (m == MODE_2) begin
      pick_tick = m2t;
    end else begin
      pick_tick = use_t2 ? t2t : t1t;
    end
  endfunction

  wire tx_tick = pick_tick(ctrl.mode, baud.tx_timer2_select,
                           t1_tick, t2_ovf, m2_tick);
  wire rx_tick = pick_tick(ctrl.mode, baud.rx_timer2_select,
                           t1_tick, t2_ovf, m2_tick);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      t1_half <= 1'b0;
      m2_pre <= 2'h0;
    end else if (ce) begin
      if (t1_ovf) begin
        t1_half <= ~t1_half;
      end
      m2_pre <= m2_tick ? 2'h0 : m2_pre + 2'h1;
    end
  end

  // ==========================================================
  // transmitter
  tx_state_t  tx_state;
  logic [3:0] tx_div;
  logic [3:0] tx_bit;
  logic [7:0] tx_data;
  logic       tx_nine;
  logic [1:0] ti_lag;

  function automatic logic bit_value(input logic [3:0] idx, input logic [7:0] d,
                                     input logic nine, input logic [3:0] last);
    if (idx == 4'h0) begin
      bit_value = 1'b0;
    end else if (idx <= 4'h8) begin
      bit_value = d[3'(idx - 4'h1)];
    end else if (idx == last) begin
      bit_value = 1'b1;
    end else begin
      bit_value = nine;
    end
  endfunction

  wire [3:0] tx_last   = nine_mode ? LAST_11BIT : LAST_10BIT;
  wire       tx_roll   = tx_tick & (tx_div == DIV_LAST);
  wire       tx_step   = (tx_state == TX_SEND) & tx_roll;
  wire       stop_done = tx_step & (tx_bit == tx_last);
  wire [3:0] next_bit  = tx_bit + 4'h1;
  wire       stop_out  = tx_step & (next_bit == tx_last) & nine_mode;
  wire       ti_set    = stop_out | (ti_lag == 2'h1);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_state <= TX_IDLE;
      tx_div <= 4'h0;
      tx_bit <= 4'h0;
      tx_data <= 8'h00;
      tx_nine <= 1'b0;
      txd <= 1'b1;
      ti_lag <= 2'h0;
    end else if (ce) begin
      if (tx_tick) begin
        tx_div <= tx_div + 4'h1;
      end
      ti_lag <= (stop_done && !nine_mode) ? TI_LAG
              : (ti_lag != 2'h0) ? ti_lag - 2'h1 : 2'h0;
      unique case (tx_state)
        TX_IDLE: begin
          txd <= 1'b1;
          if (wr_buffer && ctrl.mode != MODE_OFF) begin
            tx_data <= wdata[7:0];
            tx_nine <= ctrl.transmit_ninth_bit;
            tx_state <= TX_ARM;
          end
        end
        TX_ARM: begin
          if (tx_roll) begin
            tx_state <= TX_SEND;
            tx_bit <= 4'h0;
            txd <= 1'b0;
          end
        end
        TX_SEND: begin
          if (stop_done) begin
            tx_state <= TX_IDLE;
          end else if (tx_step) begin
            tx_bit <= next_bit;
            txd <= bit_value(next_bit, tx_data, tx_nine, tx_last);
          end
        end
        default: begin
          tx_state <= TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // receiver
  rx_state_t  rx_state;
  logic [3:0] rx_div;
  logic [3:0] rx_bit;
  logic [7:0] rx_shift;
  logic       rx_nine;
  logic       fall;
  logic       vote;

  wire sample_en = rx_tick & (rx_state == RX_RUN)
                 & (rx_div >= SAMPLE_A) & (rx_div <= SAMPLE_C);
  wire decide    = rx_tick & (rx_state == RX_RUN) & (rx_div == DECIDE);
  wire rx_start  = (rx_state == RX_IDLE) & ctrl.rx_enable
                 & (ctrl.mode != MODE_OFF) & fall;
  wire bad_start = decide & (rx_bit == 4'h0) & vote;
  wire at_stop   = decide & (rx_bit == tx_last);
  wire mp_bit    = nine_mode ? rx_nine : vote;
  wire accept    = at_stop & ~receive_complete_flag
                 & (~ctrl.multiprocessor_enable | mp_bit);

  rx_line_filter u_filter (
    .mclk      (mclk),
    .rst       (rst),
    .ce        (ce),
    .rxd       (rxd),
    .sample_en (sample_en),
    .fall      (fall),
    .vote      (vote)
  );

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_state <= RX_IDLE;
      rx_div <= 4'h0;
      rx_bit <= 4'h0;
      rx_shift <= 8'h00;
      rx_nine <= 1'b0;
    end else if (ce) begin
      unique case (rx_state)
        RX_IDLE: begin
          if (rx_start) begin
            rx_state <= RX_RUN;
            rx_div <= 4'h0;
            rx_bit <= 4'h0;
          end
        end
        RX_RUN: begin
          if (rx_tick) begin
            rx_div <= rx_div + 4'h1;
          end
          if (bad_start || at_stop) begin
            rx_state <= RX_IDLE;
          end else if (decide) begin
            rx_bit <= rx_bit + 4'h1;
            if (rx_bit <= 4'h8) begin
              rx_shift <= {vote, rx_shift[7:1]};
            end else begin
              rx_nine <= vote;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // register writes, flags, read port
  logic [DATA_W-1:0] read_word;

  always_comb begin
    read_word = '0;
    unique case (addr)
      OFS_CTRL:      read_word[4:0] = ctrl;
      OFS_STATUS:    read_word[4:0] = {rx_state == RX_RUN, tx_state != TX_IDLE,
                                       receive_ninth_bit, receive_complete_flag,
                                       transmit_complete_flag};
      OFS_BUFFER:    read_word[7:0] = serial_buffer;
      OFS_BAUD_CTRL: read_word[4:0] = baud;
      OFS_T1_RELOAD: read_word[7:0] = timer1_reload_byte;
      OFS_T2_RELOAD: read_word = {timer2_reload_high, timer2_reload_low};
      OFS_T2_STATUS: read_word[T2ST_FLAG] = t2_flag;
      default:       read_word = '0;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl <= ctrl_t'(CTRL_RST);
      baud <= baud_cfg_t'(BAUD_RST);
      timer1_reload_byte <= T1_RELOAD_RST;
      timer2_reload_high <= T2_RELOAD_RST[15:8];
      timer2_reload_low <= T2_RELOAD_RST[7:0];
      transmit_complete_flag <= 1'b0;
      receive_complete_flag <= 1'b0;
      receive_ninth_bit <= 1'b0;
      serial_buffer <= 8'h00;
      rdata <= '0;
    end else if (ce) begin
      if (wr_ctrl) ctrl <= ctrl_t'(wdata[4:0]);
      if (wr_baud) baud <= baud_cfg_t'(wdata[4:0]);
      if (wr_t1) timer1_reload_byte <= wdata[7:0];
      if (wr_t2) begin
        timer2_reload_high <= wdata[15:8];
        timer2_reload_low <= wdata[7:0];
      end
      // hardware set beats a simultaneous software clear
      transmit_complete_flag <= (transmit_complete_flag & ~clr_ti) | ti_set;
      receive_complete_flag <= (receive_complete_flag & ~clr_ri) | accept;
      if (accept) begin
        serial_buffer <= rx_shift;
        receive_ninth_bit <= mp_bit;
      end
      rdata <= rd ? read_word : '0;
    end
  end

  // ==========================================================
  // checks
  sequence s_stop_m1;
    stop_done && ctrl.mode == MODE_1;
  endsequence

  property p_ti_lag;
    @(posedge mclk) disable iff (rst | ~ce)
    s_stop_m1 |-> ##3 transmit_complete_flag;
  endproperty
  a_ti_lag: assert property (p_ti_lag)
    else $error("mode 1 transmit flag not set two cycles after stop");

  property p_ti_stop;
    @(posedge mclk) disable iff (rst | ~ce)
    stop_out |=> transmit_complete_flag && txd;
  endproperty
  a_ti_stop: assert property (p_ti_stop)
    else $error("transmit flag not set as stop bit driven");

  property p_tx_idle_high;
    @(posedge mclk) disable iff (rst | ~ce)
    tx_state != TX_SEND |-> txd;
  endproperty
  a_tx_idle_high: assert property (p_tx_idle_high)
    else $error("transmit line low outside a frame");

  property p_bad_start;
    @(posedge mclk) disable iff (rst | ~ce)
    bad_start |=> rx_state == RX_IDLE && !$rose(receive_complete_flag);
  endproperty
  a_bad_start: assert property (p_bad_start)
    else $error("unconfirmed start bit not abandoned");

  property p_reject;
    @(posedge mclk) disable iff (rst | ~ce)
    at_stop && !accept |=> $stable(serial_buffer) && $stable(receive_ninth_bit);
  endproperty
  a_reject: assert property (p_reject)
    else $error("rejected frame changed buffer");

  property p_accept;
    @(posedge mclk) disable iff (rst | ~ce)
    accept |=> receive_complete_flag && serial_buffer == $past(rx_shift)
               && rx_state == RX_IDLE;
  endproperty
  a_accept: assert property (p_accept)
    else $error("accepted frame not stored");

  property p_flags_hold;
    @(posedge mclk) disable iff (rst | ~ce)
    receive_complete_flag && !clr_ri |=> receive_complete_flag;
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("receive flag cleared without software");

  property p_rx_disabled;
    @(posedge mclk) disable iff (rst | ~ce)
    rx_state == RX_IDLE && !ctrl.rx_enable |=> rx_state == RX_IDLE;
  endproperty
  a_rx_disabled: assert property (p_rx_disabled)
    else $error("receiver started while disabled");

endmodule

// [uart_async_pkg.sv]
package uart_async_pkg;

  // ==========================================================
  // register map (byte addresses, one word each)
  localparam int          ADDR_W        = 5;
  localparam int          DATA_W        = 16;
  localparam logic [4:0]  OFS_CTRL      = 5'h00;
  localparam logic [4:0]  OFS_STATUS    = 5'h04;
  localparam logic [4:0]  OFS_BUFFER    = 5'h08;
  localparam logic [4:0]  OFS_BAUD_CTRL = 5'h0C;
  localparam logic [4:0]  OFS_T1_RELOAD = 5'h10;
  localparam logic [4:0]  OFS_T2_RELOAD = 5'h14;
  localparam logic [4:0]  OFS_T2_STATUS = 5'h18;

  // status field positions
  localparam int ST_TI      = 0;
  localparam int ST_RI      = 1;
  localparam int ST_RB8     = 2;
  localparam int ST_TX_BUSY = 3;
  localparam int ST_RX_BUSY = 4;
  localparam int T2ST_FLAG  = 0;

  // ==========================================================
  // reset values
  localparam logic [4:0]  CTRL_RST      = 5'h00;
  localparam logic [4:0]  BAUD_RST      = 5'h00;
  localparam logic [7:0]  T1_RELOAD_RST = 8'h00;
  localparam logic [15:0] T2_RELOAD_RST = 16'h0000;
  localparam logic [7:0]  T1_COUNT_RST  = 8'h00;
  localparam logic [15:0] T2_COUNT_RST  = 16'h0000;

  // ==========================================================
  // cycle counts
  localparam logic [3:0] PRE_T2_BAUD = 4'h2;
  localparam logic [3:0] PRE_FAST    = 4'h4;
  localparam logic [3:0] PRE_SLOW    = 4'hC;
  localparam logic [1:0] M2_FAST_LAST = 2'h1;
  localparam logic [1:0] M2_SLOW_LAST = 2'h3;
  localparam logic [3:0] DIV_LAST    = 4'hF;
  localparam logic [3:0] SAMPLE_A    = 4'h7;
  localparam logic [3:0] SAMPLE_C    = 4'h9;
  localparam logic [3:0] DECIDE      = 4'hA;
  localparam logic [3:0] LAST_10BIT  = 4'h9;
  localparam logic [3:0] LAST_11BIT  = 4'hA;
  localparam logic [1:0] TI_LAG      = 2'h2;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_1   = 2'b01,
    MODE_2   = 2'b10,
    MODE_3   = 2'b11
  } uart_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_ARM  = 2'b01,
    TX_SEND = 2'b10
  } tx_state_t;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_RUN  = 1'b1
  } rx_state_t;

  typedef struct packed {
    logic       transmit_ninth_bit;
    logic       multiprocessor_enable;
    logic       rx_enable;
    uart_mode_t mode;
  } ctrl_t;

  typedef struct packed {
    logic rx_timer2_select;
    logic tx_timer2_select;
    logic timer2_clock_select;
    logic timer1_clock_select;
    logic double_rate_bit;
  } baud_cfg_t;

endpackage

// [baud_timers.sv]
`timescale 1ns/10ps
module baud_timers
  import uart_async_pkg::*;
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  // configuration
  input  wire baud_cfg_t        cfg,
  input  wire logic [7:0]       timer1_reload_byte,
  input  wire logic [15:0]      t2_reload,
  input  wire logic             timer2_external_trigger,
  input  wire logic             t2_flag_clear,
  // results
  output logic                  t1_ovf,
  output logic                  t2_ovf,
  output logic                  timer2_overflow_flag
);
  // ==========================================================
  // prescalers
  logic [3:0]  pre1;
  logic [3:0]  pre2;
  logic [7:0]  t1;
  logic [15:0] t2;
  logic        trig_s1;
  logic        trig_s2;
  logic        trig_prev;
  wire         t2_baud = cfg.rx_timer2_select | cfg.tx_timer2_select;
  wire  [3:0]  lim1    = cfg.timer1_clock_select ? PRE_FAST : PRE_SLOW;
  wire  [3:0]  lim2    = t2_baud ? PRE_T2_BAUD
                       : (cfg.timer2_clock_select ? PRE_FAST : PRE_SLOW);
  wire         step1   = pre1 >= lim1 - 4'h1;
  wire         step2   = pre2 >= lim2 - 4'h1;
  wire         trig    = trig_prev & ~trig_s2 & ~t2_baud;

  assign t1_ovf = ce & step1 & (t1 == 8'hFF);
  assign t2_ovf = ce & step2 & (t2 == 16'hFFFF);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pre1 <= 4'h0;
      pre2 <= 4'h0;
      t1 <= T1_COUNT_RST;
      t2 <= T2_COUNT_RST;
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_prev <= 1'b1;
      timer2_overflow_flag <= 1'b0;
    end else if (ce) begin
      trig_s1 <= timer2_external_trigger;
      trig_s2 <= trig_s1;
      trig_prev <= trig_s2;
      pre1 <= step1 ? 4'h0 : pre1 + 4'h1;
      pre2 <= step2 ? 4'h0 : pre2 + 4'h1;
      if (step1) begin
        t1 <= (t1 == 8'hFF) ? timer1_reload_byte : t1 + 8'h01;
      end
      if (trig || t2_ovf) begin
        t2 <= t2_reload;
      end else if (step2) begin
        t2 <= t2 + 16'h0001;
      end
      // a rollover in the clearing cycle still sets the flag
      timer2_overflow_flag <= (timer2_overflow_flag & ~t2_flag_clear)
                            | (t2_ovf & ~t2_baud);
    end
  end

  property p_t2_flag_quiet;
    @(posedge mclk) disable iff (rst | ~ce)
    t2_baud && !timer2_overflow_flag |=> !timer2_overflow_flag;
  endproperty
  a_t2_flag_quiet: assert property (p_t2_flag_quiet)
    else $error("timer 2 flag set while in baud mode");

endmodule

// [rx_line_filter.sv]
`timescale 1ns/10ps
module rx_line_filter (
  // clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  // line and sampling
  input  wire logic rxd,
  input  wire logic sample_en,
  output logic      fall,
  output logic      vote
);
  logic       s1;
  logic       s2;
  logic       prev;
  logic [2:0] samples;

  function automatic logic majority(input logic [2:0] v);
    majority = (v[0] & v[1]) | (v[1] & v[2]) | (v[0] & v[2]);
  endfunction

  assign fall = prev & ~s2;
  assign vote = majority(samples);

  // idle line is high, so reset to high to avoid a false start edge
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      prev <= 1'b1;
      samples <= 3'h7;
    end else if (ce) begin
      s1 <= rxd;
      s2 <= s1;
      prev <= s2;
      if (sample_en) begin
        samples <= {samples[1:0], s2};
      end
    end
  end

endmodule

// [uart_far_node.sv]
`timescale 1ns/10ps
// ==========
// far serial node
module uart_far_node (
  // line
  input  wire logic mclk,
  input  wire logic txd,
  output logic      rxd
);
  initial rxd = 1'b1;
  // frame is start first; caller marks address bytes with ninth 1
  task automatic send(input logic [10:0] f, input int n, input int per);
    for (int i = 0; i < n; i++) begin
      @(posedge mclk);
      rxd <= f[i];
      repeat (per - 1) @(posedge mclk);
    end
  endtask
  task automatic glitch(input int len);
    @(posedge mclk);
    rxd <= 1'b0;
    repeat (len) @(posedge mclk);
    rxd <= 1'b1;
  endtask
  // samples mid-bit; unused top bit reads as 1
  task automatic grab(output logic [10:0] f, input int n, input int per);
    f = 11'h7FF;
    @(negedge txd);
    repeat (per / 2) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      if (i < n - 1) repeat (per) @(posedge mclk);
    end
  endtask
endmodule

// [serial_port_async_modes_tb_top.sv]
`timescale 1ns/10ps
module serial_port_async_modes_tb_top;
  import uart_async_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic [4:0] baud;
    logic       sm2;
    logic       nine;
    logic [7:0] data;
    logic [7:0] per;
  } row_t;
  // ==========
  // signals
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        rxd;
  logic        txd;
  logic        t2_trig = 1'b1;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  always #12.5 mclk = ~mclk;
  uart_async_port dut_u (.mclk(mclk), .rst(rst), .ce(1'b1), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .timer2_external_trigger(t2_trig), .txd(txd));
  uart_far_node far_u (.mclk(mclk), .txd(txd), .rxd(rxd));
  // ==========
  // tasks
  task automatic end_sim;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // runs far longer than the whole sequence needs
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      end_sim();
    end
  end
  // ==========
  // sequence
  row_t        rows [7];
  row_t        r;
  logic [10:0] ef;
  logic [10:0] got;
  logic [15:0] v;
  logic [7:0]  last = 8'h00;
  logic        rb8 = 1'b0;
  logic        acc;
  int          n;
  initial begin
    rows[0] = {2'h2, 5'h01, 1'b0, 1'b0, 8'hA5, 8'd32};
    rows[1] = {2'h2, 5'h01, 1'b1, 1'b1, 8'h3C, 8'd32};
    rows[2] = {2'h2, 5'h01, 1'b1, 1'b0, 8'h5A, 8'd32};
    rows[3] = {2'h3, 5'h03, 1'b0, 1'b1, 8'h81, 8'd64};
    rows[4] = {2'h1, 5'h18, 1'b1, 1'b0, 8'h7E, 8'd32};
    rows[5] = {2'h3, 5'h02, 1'b0, 1'b0, 8'hC3, 8'd128};
    rows[6] = {2'h2, 5'h00, 1'b0, 1'b0, 8'h01, 8'd64};
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    rd_reg(OFS_CTRL, v);
    chk(v, 16'h0000);
    rd_reg(5'h1C, v);
    chk(v, 16'h0000);
    chk({15'h0, txd}, 16'h0001);
    wr_reg(OFS_T1_RELOAD, 16'h00FF);
    wr_reg(OFS_T2_RELOAD, 16'hFFFF);
    // timer 2 only reloads on rollover or trigger; from zero it would take far too long
    t2_trig <= 1'b0;
    repeat (4) @(posedge mclk);
    t2_trig <= 1'b1;
    foreach (rows[i]) begin
      r = rows[i];
      wr_reg(OFS_BAUD_CTRL, {11'h0, r.baud});
      if (r.baud[3]) begin
        rd_reg(OFS_T2_STATUS, v);
        chk(v, 16'h0001);
        wr_reg(OFS_T2_STATUS, 16'h0001);
      end
      wr_reg(OFS_CTRL, {11'h0, r.nine, r.sm2, 1'b1, r.mode});
      n = (r.mode == 2'h1) ? 10 : 11;
      ef = (r.mode == 2'h1) ? {2'b11, r.data, 1'b0} : {1'b1, r.nine, r.data, 1'b0};
      fork
        far_u.grab(got, n, int'(r.per));
        wr_reg(OFS_BUFFER, {8'h00, r.data});
      join
      repeat (2 * r.per) @(posedge mclk);
      chk({5'h0, got}, {5'h0, ef});
      chk({15'h0, txd}, 16'h0001);
      far_u.send(ef, n, int'(r.per));
      repeat (8) @(posedge mclk);
      acc = !(r.sm2 && !ef[9]);
      if (acc) begin
        last = r.data;
        rb8 = ef[9];
      end
      rd_reg(OFS_STATUS, v);
      chk(v, {13'h0, rb8, acc, 1'b1});
      rd_reg(OFS_BUFFER, v);
      chk(v, {8'h00, last});
      if (r.baud[3]) begin
        rd_reg(OFS_T2_STATUS, v);
        chk(v, 16'h0000);
      end
      wr_reg(OFS_STATUS, 16'h0003);
    end
    far_u.send({2'b11, 8'h11, 1'b0}, 11, 64);
    far_u.send({2'b10, 8'h22, 1'b0}, 11, 64);
    repeat (8) @(posedge mclk);
    rd_reg(OFS_BUFFER, v);
    chk(v, 16'h0011);
    wr_reg(OFS_STATUS, 16'h0003);
    far_u.glitch(3);
    repeat (1000) @(posedge mclk);
    rd_reg(OFS_STATUS, v);
    chk(v, 16'h0004);
    far_u.send({2'b10, 8'h33, 1'b0}, 11, 64);
    repeat (8) @(posedge mclk);
    rd_reg(OFS_BUFFER, v);
    chk(v, 16'h0033);
    wr_reg(OFS_STATUS, 16'h0003);
    wr_reg(OFS_CTRL, 16'h0002);
    far_u.send({2'b11, 8'h44, 1'b0}, 11, 64);
    repeat (8) @(posedge mclk);
    rd_reg(OFS_STATUS, v);
    chk(v, 16'h0000);
    end_sim();
  end
endmodule
